//--- src/arm_regs.svh
`ifndef ARM_REGS_SVH
`define ARM_REGS_SVH
// Notes on behaviour
// - Result table holds 64 ten-bit entries.
// - Finished conversion writes entry of its command index.
// - Right unsigned view: result in bits 9..0.
// - Stop mode reads invalid, writes ignored.
// - Signed view: two's complement in bits 15..6.
// - Sign is inverted top bit, low bits zero.
// - Left unsigned view: result in bits 15..6.
// - Byte and half-word access, one register each.
// - Conversions may update entries between host reads.
// - Control-zero mux enable selects external multiplexing.
// - Channel number drives mux address and input.
// - Up to 16 external channels by number.
// - Address pins output-only in mux mode, direction bits ignored there.
// - Eight direct channels, fewer with external muxes.
// - Phases: initial sample, final sample, resolve.
// - Initial 2, final 2/4/8/16, resolve 10 cycles.
// - Amplifier bypass drops the initial sample phase.
// - Sample time code 00..11 gives 2..16.
// - Channel 63 ends queue; 60-62 skip amplifier.
// - Successive approximation MSB first, then stored.

// Host byte address map, one 128-byte window per view
`define ARM_ADDR_W 9
`define ARM_MAP_END 9'h180
`define ARM_RES_W 10
`define ARM_TBL_DEPTH 64
`define ARM_SIGN_BIT 15
`define ARM_LJ_LSB 6

// Conversion timing in conversion-clock cycles
`define ARM_INIT_CYCLES 5'h02
`define ARM_FINAL_BASE 5'h02
`define ARM_RES_CYCLES 5'h0a

// Channel numbers
`define ARM_CH_EOQ 6'h3f
`define ARM_CH_REF_LO 6'h3c
`define ARM_CH_REF_HI 6'h3d
`define ARM_CH_REF_MID 6'h3e
`define ARM_CH_P4 6'h34
`define ARM_CH_P5 6'h35
`define ARM_CH_P6 6'h37
`define ARM_CH_P7 6'h38
`endif

//--- src/arm_pkg.sv
package arm_pkg;
    // Result view selected by address bits 8:7
    typedef enum logic [1:0] {VIEW_RIGHT_U, VIEW_LEFT_S, VIEW_LEFT_U, VIEW_NONE} arm_view_t;
    // Conversion sequencer phases
    typedef enum logic [1:0] {ST_IDLE, ST_INIT, ST_FINAL, ST_RESOLVE} arm_state_t;
endpackage : arm_pkg

//--- src/arm_sar.sv
`timescale 1ns/100ps
`include "arm_regs.svh"
module arm_sar
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Conversion request
    input wire logic i_start,
    input wire logic i_bypass,
    input wire logic [1:0] i_sample_code,
    input wire logic i_comp,
    // Analog control and result
    output logic o_amp_en,
    output logic o_sample,
    output logic [`ARM_RES_W-1:0] o_trial,
    output logic o_busy,
    output logic o_done,
    output logic [`ARM_RES_W-1:0] o_result
);
    arm_pkg::arm_state_t state_ff, nxt_state;
    logic [4:0] cnt_ff, nxt_cnt;
    logic [3:0] bit_ff, nxt_bit;
    logic [`ARM_RES_W-1:0] trial_ff, nxt_trial, result_ff, nxt_result;
    logic done_ff, nxt_done, amp_ff, sample_ff, busy_ff;

    // Final sample length from the two-bit code
    function automatic logic [4:0] final_len(input logic [1:0] code);
        final_len = `ARM_FINAL_BASE << code;
    endfunction : final_len

    // Phase sequencing and bit-by-bit approximation
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_bit = bit_ff;
        nxt_trial = trial_ff;
        nxt_result = result_ff;
        nxt_done = 1'b0;
        case (state_ff)
            arm_pkg::ST_IDLE:
            begin
                if (i_start)
                begin
                    if (i_bypass)
                    begin
                        nxt_state = arm_pkg::ST_FINAL;
                        nxt_cnt = final_len(i_sample_code) - 5'h01;
                    end
                    else
                    begin
                        nxt_state = arm_pkg::ST_INIT;
                        nxt_cnt = `ARM_INIT_CYCLES - 5'h01;
                    end
                end
            end
            arm_pkg::ST_INIT:
            begin
                nxt_cnt = cnt_ff - 5'h01;
                if (cnt_ff == 5'h00)
                begin
                    nxt_state = arm_pkg::ST_FINAL;
                    nxt_cnt = final_len(i_sample_code) - 5'h01;
                end
            end
            arm_pkg::ST_FINAL:
            begin
                nxt_cnt = cnt_ff - 5'h01;
                if (cnt_ff == 5'h00)
                begin
                    nxt_state = arm_pkg::ST_RESOLVE;
                    nxt_cnt = `ARM_RES_CYCLES - 5'h01;
                    nxt_bit = 4'(`ARM_RES_W - 1);
                    nxt_trial = 10'h200;
                end
            end
            arm_pkg::ST_RESOLVE:
            begin
                // Clear the bit under test if the comparator says too high
                nxt_trial = i_comp ? trial_ff : (trial_ff & ~(10'h001 << bit_ff));
                nxt_cnt = cnt_ff - 5'h01;
                if (bit_ff == 4'h0)
                begin
                    nxt_state = arm_pkg::ST_IDLE;
                    nxt_result = nxt_trial;
                    nxt_done = 1'b1;
                end
                else
                begin
                    nxt_bit = bit_ff - 4'h1;
                    nxt_trial = nxt_trial | (10'h001 << (bit_ff - 4'h1));
                end
            end
            default:
            begin
                nxt_state = arm_pkg::ST_IDLE;
            end
        endcase
    end

    // Sequencer registers; analog strobes follow the next phase
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_ff <= arm_pkg::ST_IDLE;
            cnt_ff <= 5'h00;
            bit_ff <= 4'h0;
            trial_ff <= 10'h000;
            result_ff <= 10'h000;
            done_ff <= 1'b0;
            amp_ff <= 1'b0;
            sample_ff <= 1'b0;
            busy_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            bit_ff <= nxt_bit;
            trial_ff <= nxt_trial;
            result_ff <= nxt_result;
            done_ff <= nxt_done;
            amp_ff <= (nxt_state == arm_pkg::ST_INIT);
            sample_ff <= (nxt_state == arm_pkg::ST_INIT) || (nxt_state == arm_pkg::ST_FINAL);
            busy_ff <= (nxt_state != arm_pkg::ST_IDLE);
        end
    end

    assign o_amp_en = amp_ff;
    assign o_sample = sample_ff;
    assign o_trial = trial_ff;
    assign o_busy = busy_ff;
    assign o_done = done_ff;
    assign o_result = result_ff;
endmodule : arm_sar

//--- src/arm_top.sv
`timescale 1ns/100ps
`include "arm_regs.svh"
module arm_top
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Host register bus
    input wire logic i_bus_sel,
    input wire logic i_bus_wr,
    input wire logic [`ARM_ADDR_W-1:0] i_bus_addr,
    input wire logic [1:0] i_bus_be,
    input wire logic [15:0] i_bus_wdata,
    output logic [15:0] o_bus_rdata,
    output logic o_bus_ack,
    // Mode and port control
    input wire logic i_stop,
    input wire logic i_ext_mux_en,
    input wire logic [1:0] i_port_direction_bits,
    input wire logic [1:0] i_port_data,
    // Conversion command from queue control
    input wire logic i_conv_start,
    input wire logic [5:0] i_cmd_index,
    input wire logic [5:0] i_channel_select,
    input wire logic [1:0] i_sample_time_select,
    input wire logic i_amp_bypass,
    // Comparator from the analog array
    input wire logic i_comp,
    // Multiplexer address pins
    output logic [1:0] o_mux_address_out,
    output logic [1:0] o_mux_address_oe,
    // Analog front-end control
    output logic [2:0] o_input_sel,
    output logic [1:0] o_ref_sel,
    output logic o_amp_en,
    output logic o_sample,
    output logic [`ARM_RES_W-1:0] o_dac_code,
    // Status to queue control
    output logic o_busy,
    output logic o_eoc,
    output logic o_end_of_queue
);
    logic [`ARM_RES_W-1:0] tbl_ff [`ARM_TBL_DEPTH];
    logic [`ARM_RES_W-1:0] nxt_tbl [`ARM_TBL_DEPTH];
    logic [15:0] rdata_ff, nxt_rdata;
    logic ack_ff, nxt_ack;
    logic [5:0] idx_ff, nxt_idx;
    logic [2:0] pin_ff, nxt_pin;
    logic [1:0] ref_ff, nxt_ref;
    logic [1:0] addr_pin_ff, nxt_addr_pin;
    logic [1:0] addr_oe_ff, nxt_addr_oe;
    logic eoc_ff, eoq_ff;
    logic sar_start, sar_bypass, sar_busy, sar_done;
    logic [`ARM_RES_W-1:0] sar_result;
    arm_pkg::arm_view_t view;
    logic [5:0] hw_idx;
    logic [15:0] cur_view, merged;
    logic is_ref, accept;

    // Encode one stored entry into the chosen view
    function automatic logic [15:0] view_enc(input logic [`ARM_RES_W-1:0] raw, input arm_pkg::arm_view_t v);
        view_enc = 16'h0000;
        case (v)
            arm_pkg::VIEW_RIGHT_U: view_enc = {6'h00, raw};
            arm_pkg::VIEW_LEFT_S: view_enc = {~raw[9], raw[8:0], 6'h00};
            arm_pkg::VIEW_LEFT_U: view_enc = {raw, 6'h00};
            default: view_enc = 16'h0000;
        endcase
    endfunction : view_enc

    // Decode a written half-word back to the stored entry
    function automatic logic [`ARM_RES_W-1:0] view_dec(input logic [15:0] hw, input arm_pkg::arm_view_t v);
        view_dec = 10'h000;
        case (v)
            arm_pkg::VIEW_RIGHT_U: view_dec = hw[9:0];
            arm_pkg::VIEW_LEFT_S: view_dec = {~hw[`ARM_SIGN_BIT], hw[14:6]};
            arm_pkg::VIEW_LEFT_U: view_dec = hw[15:`ARM_LJ_LSB];
            default: view_dec = 10'h000;
        endcase
    endfunction : view_dec

    // Internal input pin for a channel number, direct or external mode
    function automatic logic [2:0] ch_pin(input logic [5:0] ch, input logic ext);
        ch_pin = 3'h0;
        if (ext && (ch[5:3] == 3'h0 || ch[5:3] == 3'h2))
        begin
            ch_pin = {1'b0, ch[4], ch[0]};
        end
        else
        begin
            case (ch)
                6'h00, 6'h01, 6'h02, 6'h03: ch_pin = ext ? 3'h0 : ch[2:0];
                `ARM_CH_P4: ch_pin = 3'h4;
                `ARM_CH_P5: ch_pin = 3'h5;
                `ARM_CH_P6: ch_pin = 3'h6;
                `ARM_CH_P7: ch_pin = 3'h7;
                default: ch_pin = 3'h0;
            endcase
        end
    endfunction : ch_pin

    // Reference source, 0 when a pin is converted
    function automatic logic [1:0] ch_ref(input logic [5:0] ch);
        ch_ref = 2'h0;
        case (ch)
            `ARM_CH_REF_LO: ch_ref = 2'h1;
            `ARM_CH_REF_HI: ch_ref = 2'h2;
            `ARM_CH_REF_MID: ch_ref = 2'h3;
            default: ch_ref = 2'h0;
        endcase
    endfunction : ch_ref

    // Command acceptance; end-of-queue code starts nothing
    assign accept = i_conv_start && !sar_busy && !i_stop;
    assign sar_start = accept && (i_channel_select != `ARM_CH_EOQ);
    assign is_ref = (ch_ref(i_channel_select) != 2'h0);
    assign sar_bypass = i_amp_bypass || is_ref;

    arm_sar u_sar
    (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_start(sar_start),
        .i_bypass(sar_bypass),
        .i_sample_code(i_sample_time_select),
        .i_comp(i_comp),
        .o_amp_en(o_amp_en),
        .o_sample(o_sample),
        .o_trial(o_dac_code),
        .o_busy(sar_busy),
        .o_done(sar_done),
        .o_result(sar_result)
    );

    // Channel latch and multiplexer address pins
    always_comb
    begin
        nxt_idx = idx_ff;
        nxt_pin = pin_ff;
        nxt_ref = ref_ff;
        nxt_addr_pin = addr_pin_ff;
        if (sar_start)
        begin
            nxt_idx = i_cmd_index;
            nxt_pin = ch_pin(i_channel_select, i_ext_mux_en);
            nxt_ref = ch_ref(i_channel_select);
            if (i_ext_mux_en)
            begin
                nxt_addr_pin = i_channel_select[2:1];
            end
        end
        // Pins are forced outputs in external mode
        if (i_ext_mux_en)
        begin
            nxt_addr_oe = 2'h3;
        end
        else
        begin
            nxt_addr_oe = i_port_direction_bits;
            nxt_addr_pin = i_port_data;
        end
    end

    // Host side view of the addressed entry
    assign view = (i_bus_addr >= `ARM_MAP_END) ? arm_pkg::VIEW_NONE : arm_pkg::arm_view_t'(i_bus_addr[8:7]);
    assign hw_idx = i_bus_addr[6:1];
    assign cur_view = view_enc(tbl_ff[hw_idx], view);
    assign merged = {i_bus_be[1] ? i_bus_wdata[15:8] : cur_view[15:8],
                     i_bus_be[0] ? i_bus_wdata[7:0] : cur_view[7:0]};

    // Result table update and bus answer
    always_comb
    begin
        for (int i = 0; i < `ARM_TBL_DEPTH; i++)
        begin
            nxt_tbl[i] = tbl_ff[i];
        end
        nxt_ack = i_bus_sel;
        nxt_rdata = 16'h0000;
        if (i_bus_sel && !i_bus_wr && !i_stop)
        begin
            nxt_rdata = cur_view;
        end
        // Host writes ignored in stop mode or outside the map
        if (i_bus_sel && i_bus_wr && !i_stop && view != arm_pkg::VIEW_NONE)
        begin
            nxt_tbl[hw_idx] = view_dec(merged, view);
        end
        // Conversion result lands last, so it wins a same-entry clash
        if (sar_done)
        begin
            nxt_tbl[idx_ff] = sar_result;
        end
    end

    // State registers
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            for (int i = 0; i < `ARM_TBL_DEPTH; i++)
            begin
                tbl_ff[i] <= 10'h000;
            end
            rdata_ff <= 16'h0000;
            ack_ff <= 1'b0;
            idx_ff <= 6'h00;
            pin_ff <= 3'h0;
            ref_ff <= 2'h0;
            addr_pin_ff <= 2'h0;
            addr_oe_ff <= 2'h0;
            eoc_ff <= 1'b0;
            eoq_ff <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < `ARM_TBL_DEPTH; i++)
            begin
                tbl_ff[i] <= nxt_tbl[i];
            end
            rdata_ff <= nxt_rdata;
            ack_ff <= nxt_ack;
            idx_ff <= nxt_idx;
            pin_ff <= nxt_pin;
            ref_ff <= nxt_ref;
            addr_pin_ff <= nxt_addr_pin;
            addr_oe_ff <= nxt_addr_oe;
            eoc_ff <= sar_done;
            eoq_ff <= accept && (i_channel_select == `ARM_CH_EOQ);
        end
    end

    // Outputs straight from flip-flops
    assign o_bus_rdata = rdata_ff;
    assign o_bus_ack = ack_ff;
    assign o_mux_address_out = addr_pin_ff;
    assign o_mux_address_oe = addr_oe_ff;
    assign o_input_sel = pin_ff;
    assign o_ref_sel = ref_ff;
    assign o_busy = sar_busy;
    assign o_eoc = eoc_ff;
    assign o_end_of_queue = eoq_ff;
endmodule : arm_top

//--- dv/arm_top_sva.sv
`timescale 1ns/100ps
module arm_top_sva
(
    // Clock, reset and host bus
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_bus_sel,
    input wire logic i_bus_wr,
    input wire logic [8:0] i_bus_addr,
    input wire logic [15:0] o_bus_rdata,
    input wire logic o_bus_ack,
    // Mode, port and command
    input wire logic i_stop,
    input wire logic i_ext_mux_en,
    input wire logic [1:0] i_port_direction_bits,
    input wire logic i_conv_start,
    input wire logic [5:0] i_channel_select,
    input wire logic [1:0] i_sample_time_select,
    input wire logic i_amp_bypass,
    // Pins and status
    input wire logic [1:0] o_mux_address_out,
    input wire logic [1:0] o_mux_address_oe,
    input wire logic o_amp_en,
    input wire logic o_sample,
    input wire logic o_busy,
    input wire logic o_eoc,
    input wire logic o_end_of_queue
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    logic go;
    logic rd;
    logic [4:0] amp_ff, smp_ff, res_ff, exp_ff, nxt_amp, nxt_smp, nxt_res, nxt_exp;
    // Accepted start and host read
    assign go = i_conv_start && !o_busy && !i_stop;
    assign rd = i_bus_sel && !i_bus_wr;
    // Phase run lengths; counts land one edge late, read at the fall
    always_comb
    begin
        nxt_amp = o_amp_en ? amp_ff + 5'h1 : 5'h0;
        nxt_smp = o_sample ? smp_ff + 5'h1 : 5'h0;
        nxt_res = (o_busy && !o_sample) ? res_ff + 5'h1 : 5'h0;
        nxt_exp = exp_ff;
        if (go)
            nxt_exp = ((i_amp_bypass || i_channel_select > 6'h3b) ? 5'h0 : 5'h2) + (5'h2 << i_sample_time_select);
    end
    always_ff @(posedge i_clock or negedge i_rst_n)
        if (!i_rst_n)
            {amp_ff, smp_ff, res_ff, exp_ff} <= 20'h0;
        else
            {amp_ff, smp_ff, res_ff, exp_ff} <= {nxt_amp, nxt_smp, nxt_res, nxt_exp};
    // Phase steps
    sequence s_init; (o_amp_en && o_sample) [*2]; endsequence
    sequence s_final; !o_amp_en && o_sample && o_busy; endsequence
    property p_ack; i_bus_sel |=> o_bus_ack; endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    property p_zero; rd && (i_stop || i_bus_addr >= 9'h180) |=> o_bus_rdata == 16'h0; endproperty
    a_zero: assert property (p_zero) else $error("stop read data");
    property p_rj; rd && i_bus_addr[8:7] == 2'h0 |=> o_bus_rdata[15:10] == 6'h0; endproperty
    a_rj: assert property (p_rj) else $error("right view high bits");
    property p_lj; rd && i_bus_addr[8:7] inside {2'h1, 2'h2} |=> o_bus_rdata[5:0] == 6'h0; endproperty
    a_lj: assert property (p_lj) else $error("left view low bits");
    property p_oe; i_ext_mux_en |=> o_mux_address_oe == 2'h3; endproperty
    a_oe: assert property (p_oe) else $error("mux pins not output");
    property p_dir; !i_ext_mux_en |=> o_mux_address_oe == $past(i_port_direction_bits); endproperty
    a_dir: assert property (p_dir) else $error("direction bits lost");
    property p_addr; go && i_ext_mux_en && i_channel_select < 6'h3c |=> o_mux_address_out == $past(i_channel_select[2:1]); endproperty
    a_addr: assert property (p_addr) else $error("mux address");
    property p_eoq; go && i_channel_select == 6'h3f |=> o_end_of_queue && !o_busy; endproperty
    a_eoq: assert property (p_eoq) else $error("end of queue");
    property p_seq; go && !i_amp_bypass && i_channel_select < 6'h3c |=> s_init ##1 s_final; endproperty
    a_seq: assert property (p_seq) else $error("phase order");
    // End-of-queue code converts nothing, so it is kept out here
    property p_byp; go && i_channel_select != 6'h3f && (i_amp_bypass || i_channel_select inside {[6'h3c:6'h3e]}) |=> s_final; endproperty
    a_byp: assert property (p_byp) else $error("bypass kept amp");
    property p_amp; $fell(o_amp_en) |-> amp_ff == 5'h2 && o_sample; endproperty
    a_amp: assert property (p_amp) else $error("initial length");
    property p_smp; $fell(o_sample) |-> smp_ff == exp_ff && o_busy; endproperty
    a_smp: assert property (p_smp) else $error("sample length");
    property p_res; $fell(o_busy) |-> res_ff == 5'ha ##1 o_eoc ##1 !o_eoc; endproperty
    a_res: assert property (p_res) else $error("resolve length");
endmodule : arm_top_sva
bind arm_top arm_top_sva u_sva (.*);

//--- dv/arm_mux_model.sv
`timescale 1ns/100ps
module arm_mux_model
(
    // Pins from the converter
    input wire logic i_ext,
    input wire logic [1:0] i_addr,
    input wire logic [1:0] i_oe,
    input wire logic [2:0] i_pin,
    input wire logic [1:0] i_ref,
    input wire logic [9:0] i_code,
    // Comparator back to the converter
    output logic o_comp
);
    logic [9:0] level;
    // Every pin and address pair has its own level, so a wrong select shows
    // Address pins steer the external chips only in mux mode; GPIO use is ignored
    always_comb
    begin
        level = {i_pin, (i_ext && i_oe == 2'h3) ? i_addr : 2'h0, 5'h0b};
        case (i_ref)
            2'h1: level = 10'h000;
            2'h2: level = 10'h3ff;
            2'h3: level = 10'h200;
            default: ;
        endcase
        o_comp = (level >= i_code);
    end
endmodule : arm_mux_model

//--- dv/tb_top.sv
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; $display("ERROR %0t: got %h want %h", $time, (a), (b)); end end
module tb_top;
    logic i_clock = 1'h0, i_rst_n = 1'h0, i_bus_sel = 1'h0, i_bus_wr = 1'h0, i_stop = 1'h0, i_ext_mux_en = 1'h0;
    logic i_conv_start = 1'h0, i_amp_bypass = 1'h0, i_comp, o_bus_ack, o_amp_en, o_sample, o_busy, o_eoc, o_end_of_queue;
    logic [8:0] i_bus_addr = 9'h0;
    logic [1:0] i_bus_be = 2'h0, i_port_direction_bits = 2'h0, i_port_data = 2'h0, i_sample_time_select = 2'h0;
    logic [1:0] o_mux_address_out, o_mux_address_oe, o_ref_sel;
    logic [15:0] i_bus_wdata = 16'h0, o_bus_rdata;
    logic [5:0] i_cmd_index = 6'h0, i_channel_select = 6'h0, c, r;
    logic [2:0] o_input_sel;
    logic [9:0] o_dac_code, v, mem [64];
    logic [16:0] e, q [$];
    logic x;
    logic [5:0] chs [10] = '{6'h02, 6'h35, 6'h38, 6'h3c, 6'h3d, 6'h3e, 6'h01, 6'h06, 6'h11, 6'h16};
    int miscompares = 0, n_tests = 0, j, k;
    always #50 i_clock = ~i_clock;
    arm_top DUT (.*);
    arm_mux_model u_mux (.i_ext(i_ext_mux_en), .i_addr(o_mux_address_out), .i_oe(o_mux_address_oe), .i_pin(o_input_sel),
        .i_ref(o_ref_sel), .i_code(o_dac_code), .o_comp(i_comp));
    // Level the far side shows for a channel
    function automatic logic [9:0] lvl(input logic [5:0] ch, input logic ext);
        if (ch > 6'h3b)
            return (ch == 6'h3c) ? 10'h000 : (ch == 6'h3d) ? 10'h3ff : 10'h200;
        if (ext)
            return {1'h0, ch[4], ch[0], ch[2:1], 5'h0b};
        return {ch[2:0] - 3'(ch > 6'h36), 7'h0b};
    endfunction : lvl
    // One request per cycle; for reads the data word is the expected answer
    task bus(input logic w, input logic [8:0] a, input logic [1:0] be, input logic [15:0] d);
        @(posedge i_clock);
        #10;
        {i_bus_sel, i_bus_wr, i_bus_addr, i_bus_be, i_bus_wdata} = {1'h1, w, a, be, d};
        q.push_back({!w, d});
    endtask : bus
    task idle();
        @(posedge i_clock);
        #10;
        i_bus_sel = 1'h0;
    endtask : idle
    task rd3(input int i);
        v = mem[i];
        bus(1'h0, {2'h0, 6'(i), 1'h0}, 2'h3, {6'h0, v});
        bus(1'h0, {2'h1, 6'(i), 1'h0}, 2'h3, {~v[9], v[8:0], 6'h0});
        bus(1'h0, {2'h2, 6'(i), 1'h0}, 2'h3, {v, 6'h0});
    endtask : rd3
    task conclude();
        $display("n_tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    // Each answer is matched against the oldest note
    always @(negedge i_clock)
        if (o_bus_ack === 1'h1)
        begin
            e = (q.size() > 0) ? q.pop_front() : 17'h1dead;
            if (e[16])
                `CHK(o_bus_rdata, e[15:0])
        end
    initial
    begin
        #5000000;
        miscompares++;
        $display("ERROR %0t: run timed out", $time);
        conclude();
    end
    initial
    begin
        void'($urandom(15489));
        repeat (3) @(posedge i_clock);
        #10;
        i_rst_n = 1'h1;
        // Boundary and random values through all three views, junk outside the field
        for (j = 0; j < 64; j++)
        begin
            v = (j == 0) ? 10'h000 : (j == 1) ? 10'h200 : (j == 2) ? 10'h3ff : 10'($urandom);
            r = 6'($urandom);
            mem[j] = v;
            case (j % 3)
                0: bus(1'h1, {2'h0, 6'(j), 1'h0}, 2'h3, {r, v});
                1: bus(1'h1, {2'h1, 6'(j), 1'h0}, 2'h3, {~v[9], v[8:0], r});
                default: bus(1'h1, {2'h2, 6'(j), 1'h0}, 2'h3, {v, r});
            endcase
        end
        for (j = 0; j < 64; j++)
            rd3(j);
        // Single-lane writes merge with the other lane
        bus(1'h1, 9'h000, 2'h1, 16'h5aa5);
        bus(1'h1, 9'h102, 2'h2, 16'hc35a);
        mem[0] = {mem[0][9:8], 8'ha5};
        mem[1] = {8'hc3, mem[1][1:0]};
        rd3(0);
        rd3(1);
        idle();
        // Stop mode reads zero and drops writes; unmapped likewise
        i_stop = 1'h1;
        bus(1'h1, 9'h004, 2'h3, 16'h0155);
        bus(1'h0, 9'h004, 2'h3, 16'h0);
        idle();
        i_stop = 1'h0;
        bus(1'h1, 9'h1fe, 2'h3, 16'hffff);
        bus(1'h0, 9'h180, 2'h3, 16'h0);
        rd3(2);
        // Release the bus so the last read is not taken twice
        idle();
        // Conversions over every sample code, direct, reference and muxed inputs
        for (j = 0; j < 10; j++)
        begin
            c = chs[j];
            x = (j > 5);
            @(posedge i_clock);
            #10;
            {i_ext_mux_en, i_channel_select, i_cmd_index} = {x, c, 6'(j + 8)};
            {i_port_direction_bits, i_port_data, i_amp_bypass} = 5'($urandom);
            i_sample_time_select = j[1:0];
            i_conv_start = 1'h1;
            bus(1'h0, {2'h0, 6'(j + 9), 1'h0}, 2'h3, {6'h0, mem[j + 9]});
            i_conv_start = 1'h0;
            idle();
            for (k = 0; k < 40 && o_eoc !== 1'h1; k++)
                @(negedge i_clock);
            if (k == 40)
            begin
                miscompares++;
                $display("ERROR %0t: no end of conversion", $time);
                conclude();
            end
            mem[j + 8] = lvl(c, x);
            rd3(j + 8);
            idle();
        end
        // End-of-queue code converts nothing
        i_channel_select = 6'h3f;
        i_conv_start = 1'h1;
        @(posedge i_clock);
        #10;
        i_conv_start = 1'h0;
        `CHK(o_end_of_queue, 1'h1)
        repeat (3) @(posedge i_clock);
        if (q.size() != 0)
        begin
            miscompares++;
            $display("ERROR %0t: unanswered bus requests", $time);
        end
        conclude();
    end
endmodule : tb_top
